// ### rtl/priv_insn_defines.svh
// Constants for the privileged instruction decode block
`ifndef PRIV_INSN_DEFINES_SVH
`define PRIV_INSN_DEFINES_SVH

// ----------------------------------------
// Primary opcodes
// ----------------------------------------
`define OPC_MFPR        6'h19
`define OPC_LD          6'h1B
`define OPC_REI         6'h1E
`define OPC_MTPR        6'h1D
`define OPC_ST          6'h1F

// ----------------------------------------
// Instruction field positions
// ----------------------------------------
`define F_OPC_HI        31
`define F_OPC_LO        26
`define F_SRC_HI        25
`define F_SRC_LO        21
`define F_BASE_HI       20
`define F_BASE_LO       16
`define F_SCRATCH       7
`define F_MEM_SEL       6
`define F_FETCH_SEL     5
`define F_IDX_HI        4
`define F_IDX_LO        0
`define F_PHYS          15
`define F_OVR           14
`define F_WCHK          13
`define F_QUAD          12
`define F_OFS_HI        11
`define F_HINT_HI       15
`define F_HINT_LO       14
`define ZERO_REG        5'h1F
`define KERNEL_MODE     2'h0

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_FETCH_CTRL  6'h00
`define REG_CUR_MODE    6'h04
`define REG_OVR_MODE    6'h08
`define REG_EXC_LO      6'h0C
`define REG_EXC_HI      6'h10
`define REG_STATUS      6'h14
`define REG_FPTR_LO     6'h18
`define REG_FPTR_HI     6'h1C
`define KERN_EN_BIT     0
`define EXC_RET_INDEX   5'h00

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FW_MODE     1'b1
`define RST_MODE        2'h0

`endif

// ### rtl/priv_insn_pkg.sv
// Types shared by the privileged instruction decode block
package priv_insn_pkg;

  typedef enum logic [2:0]
  {
    OP_NONE = 3'b000,
    OP_MFPR = 3'b001,
    OP_MTPR = 3'b010,
    OP_LD   = 3'b011,
    OP_ST   = 3'b100,
    OP_REI  = 3'b101
  } op_kind_t;

endpackage

// ### rtl/priv_ls_addr.sv
// Effective address and access flags of a privileged load or store
`timescale 1ns/100ps
`include "priv_insn_defines.svh"

module priv_ls_addr
#(
  parameter int ADDR_W = 64
)
(
  // Instruction and base operand
  input  wire logic [31:0]       insn,
  input  wire logic [ADDR_W-1:0] base,
  // Decoded access
  output logic [ADDR_W-1:0]      eff_addr,
  output logic                   phys,
  output logic                   lock,
  output logic                   quad,
  output logic                   ovr_mode,
  output logic                   wr_chk
);

  generate
    if (ADDR_W < 16)
    begin : g_chk
      $error("priv_ls_addr: ADDR_W too small");
    end
  endgenerate

  logic [ADDR_W-1:0] sum;
  logic [ADDR_W-1:0] mask;

  always_comb
  begin
    // Offset is a signed 12-bit byte count
    sum  = base + {{(ADDR_W-12){insn[`F_OFS_HI]}}, insn[`F_OFS_HI:0]};
    mask = {{(ADDR_W-3){1'b1}}, ~insn[`F_QUAD], 2'b00};
    eff_addr = sum & mask;
    phys     = insn[`F_PHYS];
    ovr_mode = insn[`F_OVR];
    lock     = insn[`F_PHYS] & insn[`F_OVR];
    quad     = insn[`F_QUAD];
    wr_chk   = insn[`F_WCHK] & ~insn[`F_PHYS];
  end

endmodule // priv_ls_addr

// ### rtl/privileged_insn_decode.sv
// Decode and execute of the five privileged hardware instructions
`timescale 1ns/100ps
`include "priv_insn_defines.svh"

module privileged_insn_decode
  import priv_insn_pkg::*;
#(
  parameter int SCRATCH_DEPTH = 32
)
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Avalon-MM register slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Issue from the pipeline
  input  wire logic        insn_valid,
  input  wire logic [31:0] insn_word,
  input  wire logic [63:0] src_data,
  input  wire logic [63:0] base_data,
  input  wire logic        operand_hazard,
  output logic             insn_ready,
  output logic             illegal_opcode_fault,
  // Exception entry
  input  wire logic        enter_firmware,
  input  wire logic [63:0] exc_pc,
  // Internal register access to other units
  input  wire logic [63:0] mem_ipr_rdata,
  input  wire logic [63:0] fetch_ipr_rdata,
  output logic             mem_ipr_we,
  output logic             fetch_ipr_we,
  output logic [4:0]       ipr_index,
  output logic [63:0]      ipr_wdata,
  // Result to the integer register file
  output logic             gpr_we,
  output logic [4:0]       gpr_index,
  output logic [63:0]      gpr_wdata,
  // Memory request
  output logic             mem_req,
  output logic             mem_write,
  output logic [63:0]      mem_addr,
  output logic [63:0]      mem_wdata,
  output logic             mem_phys,
  output logic             mem_lock,
  output logic             mem_quad,
  output logic [1:0]       mem_mode,
  output logic             mem_write_check,
  // Fetch redirect
  output logic             redirect,
  output logic [63:0]      fetch_pointer,
  output logic             firmware_mode,
  output logic             ras_push,
  output logic [63:0]      ras_push_data,
  output logic [1:0]       pred_hint
);

  generate
    if (SCRATCH_DEPTH < 1 || SCRATCH_DEPTH > 32)
    begin : g_chk
      $error("privileged_insn_decode: SCRATCH_DEPTH must be 1..32");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic        kern_en_q;
  logic [1:0]  cur_mode_q;
  logic [1:0]  ovr_mode_q;
  logic [63:0] exc_ret_q;
  logic [63:0] fptr_q;
  logic        fw_mode_q;
  logic [7:0]  fault_cnt_q;
  logic        resp_q;
  logic [31:0] rdata_q;
  logic [63:0] scratch_q [SCRATCH_DEPTH];

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic [5:0]  opc;
  logic [4:0]  src_fld;
  logic [4:0]  base_fld;
  logic [4:0]  idx;
  logic        sel_scr;
  logic        sel_mem;
  logic        sel_fetch;
  op_kind_t    kind;

  assign opc       = insn_word[`F_OPC_HI:`F_OPC_LO];
  assign src_fld   = insn_word[`F_SRC_HI:`F_SRC_LO];
  assign base_fld  = insn_word[`F_BASE_HI:`F_BASE_LO];
  assign idx       = insn_word[`F_IDX_HI:`F_IDX_LO];
  assign sel_scr   = insn_word[`F_SCRATCH];
  assign sel_mem   = insn_word[`F_MEM_SEL];
  assign sel_fetch = insn_word[`F_FETCH_SEL];

  always_comb
  begin
    if (opc == `OPC_MFPR)
      kind = OP_MFPR;
    else if (opc == `OPC_MTPR)
      kind = OP_MTPR;
    else if (opc == `OPC_LD)
      kind = OP_LD;
    else if (opc == `OPC_ST)
      kind = OP_ST;
    else if (opc == `OPC_REI)
      kind = OP_REI;
    else
      kind = OP_NONE;
  end

  // ----------------------------------------
  // Privilege and issue control
  // ----------------------------------------
  logic priv;
  logic allowed;
  logic uses_gpr;
  logic rei_bad;
  logic stall;
  logic fire;
  logic fault;

  assign priv     = insn_valid && (kind != OP_NONE);
  assign allowed  = fw_mode_q
                 || (kern_en_q && cur_mode_q == `KERNEL_MODE);
  assign uses_gpr = kind != OP_REI;
  assign rei_bad  = (kind == OP_REI)
                 && (src_fld != `ZERO_REG || base_fld != `ZERO_REG);
  assign stall    = priv && allowed
                 && ((uses_gpr && operand_hazard) || rei_bad);
  assign fire     = priv && allowed && !stall;
  assign fault    = priv && !allowed;

  assign insn_ready = !stall;

  // ----------------------------------------
  // Load/store address unit
  // ----------------------------------------
  logic [63:0] ls_addr;
  logic        ls_phys;
  logic        ls_lock;
  logic        ls_quad;
  logic        ls_ovr;
  logic        ls_wchk;

  priv_ls_addr #(.ADDR_W(64)) u_ls_addr
  (
    .insn     (insn_word),
    .base     (base_data),
    .eff_addr (ls_addr),
    .phys     (ls_phys),
    .lock     (ls_lock),
    .quad     (ls_quad),
    .ovr_mode (ls_ovr),
    .wr_chk   (ls_wchk)
  );

  // ----------------------------------------
  // Internal register read for move-from
  // ----------------------------------------
  logic [63:0] ipr_rd;
  logic        scr_hit;
  logic        exc_sel;

  assign scr_hit = 32'(idx) < SCRATCH_DEPTH;
  assign exc_sel = idx == `EXC_RET_INDEX;

  always_comb
  begin
    ipr_rd = 64'h0;
    if (sel_scr && scr_hit)
      ipr_rd = ipr_rd | scratch_q[idx];
    if (sel_mem)
      ipr_rd = ipr_rd | mem_ipr_rdata;
    if (sel_fetch)
      ipr_rd = ipr_rd | (exc_sel ? exc_ret_q : fetch_ipr_rdata);
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic bus_req;
  logic bus_take;

  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !resp_q;
  assign bus_take        = bus_req && resp_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      resp_q <= 1'b0;
    else
      resp_q <= bus_req && !resp_q;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 32'h0;
    else if (avs_read && !resp_q)
    begin
      if (avs_address == `REG_FETCH_CTRL)
        rdata_q <= {31'h0, kern_en_q};
      else if (avs_address == `REG_CUR_MODE)
        rdata_q <= {30'h0, cur_mode_q};
      else if (avs_address == `REG_OVR_MODE)
        rdata_q <= {30'h0, ovr_mode_q};
      else if (avs_address == `REG_EXC_LO)
        rdata_q <= exc_ret_q[31:0];
      else if (avs_address == `REG_EXC_HI)
        rdata_q <= exc_ret_q[63:32];
      else if (avs_address == `REG_STATUS)
        rdata_q <= {16'h0, fault_cnt_q, 7'h0, fw_mode_q};
      else if (avs_address == `REG_FPTR_LO)
        rdata_q <= fptr_q[31:0];
      else if (avs_address == `REG_FPTR_HI)
        rdata_q <= fptr_q[63:32];
      else
        rdata_q <= 32'h0;
    end
  end

  logic wr_ctrl;
  logic wr_cur;
  logic wr_ovr;
  logic wr_exc_lo;
  logic wr_exc_hi;

  assign wr_ctrl   = bus_take && avs_write && avs_address == `REG_FETCH_CTRL;
  assign wr_cur    = bus_take && avs_write && avs_address == `REG_CUR_MODE;
  assign wr_ovr    = bus_take && avs_write && avs_address == `REG_OVR_MODE;
  assign wr_exc_lo = bus_take && avs_write && avs_address == `REG_EXC_LO;
  assign wr_exc_hi = bus_take && avs_write && avs_address == `REG_EXC_HI;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      kern_en_q <= 1'b0;
    else if (wr_ctrl)
      kern_en_q <= avs_writedata[`KERN_EN_BIT];
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cur_mode_q <= `RST_MODE;
    else if (wr_cur)
      cur_mode_q <= avs_writedata[1:0];
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ovr_mode_q <= `RST_MODE;
    else if (wr_ovr)
      ovr_mode_q <= avs_writedata[1:0];
  end

  // Exception entry wins over an instruction, which wins over the bus
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      exc_ret_q <= 64'h0;
    else if (enter_firmware)
      exc_ret_q <= exc_pc;
    else if (fire && kind == OP_MTPR && sel_fetch && exc_sel)
      exc_ret_q <= src_data;
    else if (wr_exc_lo)
      exc_ret_q[31:0] <= avs_writedata;
    else if (wr_exc_hi)
      exc_ret_q[63:32] <= avs_writedata;
  end

  // ----------------------------------------
  // Firmware mode and fetch pointer
  // ----------------------------------------
  logic do_rei;

  assign do_rei = fire && kind == OP_REI;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      fw_mode_q <= `RST_FW_MODE;
    else if (enter_firmware)
      fw_mode_q <= 1'b1;
    else if (do_rei)
      fw_mode_q <= exc_ret_q[0];
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      fptr_q <= 64'h0;
    else if (do_rei)
      fptr_q <= {exc_ret_q[63:2], 2'b00};
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      redirect      <= 1'b0;
      ras_push      <= 1'b0;
      ras_push_data <= 64'h0;
      pred_hint     <= 2'h0;
    end
    else
    begin
      redirect <= do_rei;
      ras_push <= do_rei;
      if (do_rei)
      begin
        ras_push_data <= exc_ret_q;
        pred_hint     <= insn_word[`F_HINT_HI:`F_HINT_LO];
      end
    end
  end

  assign fetch_pointer = fptr_q;
  assign firmware_mode = fw_mode_q;

  // ----------------------------------------
  // Fault report
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      illegal_opcode_fault <= 1'b0;
    else
      illegal_opcode_fault <= fault;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      fault_cnt_q <= 8'h0;
    else if (fault && fault_cnt_q != 8'hFF)
      fault_cnt_q <= fault_cnt_q + 8'h1;
  end

  // ----------------------------------------
  // Scratch file
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (fire && kind == OP_MTPR && sel_scr && scr_hit)
      scratch_q[idx] <= src_data;
  end

  // ----------------------------------------
  // Internal register moves
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_ipr_we   <= 1'b0;
      fetch_ipr_we <= 1'b0;
      ipr_index    <= 5'h0;
      ipr_wdata    <= 64'h0;
    end
    else
    begin
      mem_ipr_we   <= fire && kind == OP_MTPR && sel_mem;
      fetch_ipr_we <= fire && kind == OP_MTPR && sel_fetch;
      if (fire && (kind == OP_MTPR || kind == OP_MFPR))
      begin
        ipr_index <= idx;
        ipr_wdata <= src_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gpr_we    <= 1'b0;
      gpr_index <= 5'h0;
      gpr_wdata <= 64'h0;
    end
    else
    begin
      gpr_we <= fire && kind == OP_MFPR && src_fld != `ZERO_REG;
      if (fire && kind == OP_MFPR)
      begin
        gpr_index <= src_fld;
        gpr_wdata <= ipr_rd;
      end
    end
  end

  // ----------------------------------------
  // Memory requests
  // ----------------------------------------
  logic do_ls;

  assign do_ls = fire && (kind == OP_LD || kind == OP_ST);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      mem_req <= 1'b0;
    else
      mem_req <= do_ls;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_write       <= 1'b0;
      mem_addr        <= 64'h0;
      mem_wdata       <= 64'h0;
      mem_phys        <= 1'b0;
      mem_lock        <= 1'b0;
      mem_quad        <= 1'b0;
      mem_mode        <= `RST_MODE;
      mem_write_check <= 1'b0;
    end
    else if (do_ls)
    begin
      mem_write       <= kind == OP_ST;
      mem_addr        <= ls_addr;
      mem_wdata       <= src_data;
      mem_phys        <= ls_phys;
      mem_lock        <= ls_lock;
      mem_quad        <= ls_quad;
      mem_mode        <= ls_ovr ? ovr_mode_q : cur_mode_q;
      mem_write_check <= ls_wchk && kind == OP_LD;
    end
  end

endmodule // privileged_insn_decode

// ### test/priv_decode_sva.sv
// Concurrent checks on the privileged instruction decode ports
`timescale 1ns/100ps
`include "priv_insn_defines.svh"
module priv_decode_chk
(
  // Clock, reset and issue
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        insn_valid,
  input wire logic [31:0] insn_word,
  input wire logic [63:0] src_data,
  input wire logic [63:0] base_data,
  input wire logic        operand_hazard,
  input wire logic        insn_ready,
  input wire logic        illegal_opcode_fault,
  // Effects
  input wire logic        mem_ipr_we,
  input wire logic        fetch_ipr_we,
  input wire logic [63:0] ipr_wdata,
  input wire logic        gpr_we,
  input wire logic        mem_req,
  input wire logic [63:0] mem_addr,
  input wire logic        mem_phys,
  input wire logic        mem_lock,
  input wire logic        mem_quad,
  input wire logic        redirect,
  input wire logic [63:0] fetch_pointer,
  input wire logic        firmware_mode,
  input wire logic        ras_push,
  input wire logic [63:0] ras_push_data,
  input wire logic [1:0]  pred_hint
);
  logic [5:0]  opc;
  logic        priv;
  logic        fw_take;
  logic [63:0] ea;
  assign opc = insn_word[31:26];
  assign priv = opc inside {`OPC_MFPR, `OPC_LD, `OPC_REI, `OPC_MTPR, `OPC_ST};
  assign fw_take = insn_valid && insn_ready && firmware_mode;
  assign ea = (base_data + {{52{insn_word[11]}}, insn_word[11:0]})
              & ~{61'h0, insn_word[12], 2'h3};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  fault_quiet_a: assert property (
    illegal_opcode_fault |-> !(mem_req || gpr_we || mem_ipr_we || fetch_ipr_we || redirect)
    && $stable(fetch_pointer)) else $error("fault with side effect");
  fault_cause_a: assert property (
    illegal_opcode_fault |-> $past(insn_valid && insn_ready && priv && !firmware_mode))
    else $error("fault without cause");
  fw_no_fault_a: assert property (
    fw_take |=> !illegal_opcode_fault) else $error("fault in firmware mode");
  hazard_stall_a: assert property (
    insn_valid && firmware_mode && operand_hazard && priv && opc != `OPC_REI
    |-> !insn_ready) else $error("hazard not stalled");
  rei_stall_a: assert property (
    insn_valid && firmware_mode && opc == `OPC_REI && insn_word[25:16] != 10'h3FF
    |-> !insn_ready) else $error("return fields not stalled");
  rei_target_a: assert property (
    fw_take && opc == `OPC_REI |=> redirect && ras_push
    && fetch_pointer == (ras_push_data & ~64'h3) && firmware_mode == ras_push_data[0]
    && pred_hint == $past(insn_word[15:14])) else $error("return target wrong");
  ls_addr_a: assert property (
    fw_take && (opc == `OPC_LD || opc == `OPC_ST) |=> mem_req && mem_addr == $past(ea)
    && mem_phys == $past(insn_word[15]) && mem_lock == $past(insn_word[15] & insn_word[14])
    && mem_quad == $past(insn_word[12])) else $error("load store request wrong");
  mtpr_sel_a: assert property (
    fw_take && opc == `OPC_MTPR |=> mem_ipr_we == $past(insn_word[6])
    && fetch_ipr_we == $past(insn_word[5]) && ipr_wdata == $past(src_data))
    else $error("move-to selects wrong");
  mfpr_gpr_a: assert property (
    fw_take && opc == `OPC_MFPR && insn_word[25:21] != 5'h1F |=> gpr_we)
    else $error("move-from no write");
  cover property (illegal_opcode_fault);
  cover property (redirect);
  cover property (mem_req && mem_lock);
endmodule // priv_decode_chk

bind privileged_insn_decode priv_decode_chk chk (.sys_clk, .rstn, .insn_valid, .insn_word,
  .src_data, .base_data, .operand_hazard, .insn_ready, .illegal_opcode_fault, .mem_ipr_we,
  .fetch_ipr_we, .ipr_wdata, .gpr_we, .mem_req, .mem_addr, .mem_phys, .mem_lock, .mem_quad,
  .redirect, .fetch_pointer, .firmware_mode, .ras_push, .ras_push_data, .pred_hint);

// ### test/unit_regs_model.sv
// Model of the memory and fetch unit internal registers
`timescale 1ns/100ps
module unit_regs_model
(
  // Clock and issued word
  input wire logic        sys_clk,
  input wire logic [31:0] insn_word,
  // Writes from the block
  input wire logic        mem_ipr_we,
  input wire logic        fetch_ipr_we,
  input wire logic [4:0]  ipr_index,
  input wire logic [63:0] ipr_wdata,
  // Read data to the block
  output logic [63:0]     mem_ipr_rdata,
  output logic [63:0]     fetch_ipr_rdata
);
  logic [63:0] mem_q [32];
  logic [63:0] fetch_q [32];
  // Both units may take the same write in one cycle
  always_ff @(posedge sys_clk)
  begin
    if (mem_ipr_we)
      mem_q[ipr_index] <= ipr_wdata;
    if (fetch_ipr_we)
      fetch_q[ipr_index] <= ipr_wdata;
  end
  assign mem_ipr_rdata = mem_q[insn_word[4:0]];
  assign fetch_ipr_rdata = fetch_q[insn_word[4:0]];
endmodule // unit_regs_model

// ### test/testbench.sv
// Self-checking bench for the privileged instruction decode block
`timescale 1ns/100ps
`include "priv_insn_defines.svh"
module testbench;
  import priv_insn_pkg::*;
  logic sys_clk, rstn, avs_read, avs_write, avs_waitrequest, insn_valid, operand_hazard;
  logic insn_ready, illegal_opcode_fault, enter_firmware, mem_ipr_we, fetch_ipr_we, gpr_we;
  logic mem_req, mem_write, mem_phys, mem_lock, mem_quad, mem_write_check, redirect;
  logic firmware_mode, ras_push;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, insn_word;
  logic [63:0] src_data, base_data, exc_pc, mem_ipr_rdata, fetch_ipr_rdata, ipr_wdata;
  logic [63:0] gpr_wdata, mem_addr, mem_wdata, fetch_pointer, ras_push_data, rd, sd, bd, x;
  logic [4:0]  ipr_index, gpr_index;
  logic [1:0]  mem_mode, pred_hint;
  logic [31:0] f;
  logic [5:0]  ops [5] = '{`OPC_MFPR, `OPC_LD, `OPC_REI, `OPC_MTPR, `OPC_ST};
  int errors, cmp_count, seed, cyc;

  privileged_insn_decode dut (.*);
  unit_regs_model partner (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      results();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= wd;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = {32'h0, avs_readdata};
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic issue(input logic [31:0] w);
    @(posedge sys_clk);
    insn_valid <= 1'b1;
    insn_word <= w;
    src_data <= sd;
    base_data <= bd;
    do @(posedge sys_clk); while (insn_ready !== 1'b1);
    insn_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic hold(input logic [31:0] w);
    @(posedge sys_clk);
    insn_valid <= 1'b1;
    insn_word <= w;
    @(negedge sys_clk);
    chk("insn_ready", 0, insn_ready);
    @(posedge sys_clk);
    insn_valid <= 1'b0;
  endtask
  task automatic rei(input logic [63:0] v);
    bus(1, `REG_EXC_LO, v[31:0]);
    bus(1, `REG_EXC_HI, v[63:32]);
    issue({`OPC_REI, 10'h3FF, 16'h8000});
    chk("redirect", 1, redirect);
    chk("fetch_pointer", v & ~64'h3, fetch_pointer);
    chk("firmware_mode", v[0], firmware_mode);
    chk("ras_push_data", v, ras_push_data);
    chk("ras_push", 1, ras_push);
    chk("pred_hint", 2, pred_hint);
  endtask
  task automatic ldf(input logic e);
    issue({`OPC_LD, 10'h42, 16'h0010});
    chk("fault", e, illegal_opcode_fault);
    chk("mem_req", !e, mem_req);
  endtask
  function automatic logic [63:0] ea(input logic [63:0] b, input logic [15:0] g);
    return (b + {{52{g[11]}}, g[11:0]}) & ~{61'h0, g[12], 2'h3};
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    seed = 86130;
    {avs_read, avs_write, insn_valid, operand_hazard, enter_firmware} = '0;
    {avs_address, avs_writedata, insn_word, src_data, base_data, exc_pc} = '0;
    {sd, bd} = '0;
    rstn = 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    bus(0, `REG_FETCH_CTRL, 0);
    chk("fetch_ctrl", 0, rd);
    bus(1, 6'h3C, 32'hFFFFFFFF);
    bus(0, 6'h3C, 0);
    chk("unmapped", 0, rd);
    bus(1, `REG_CUR_MODE, 1);
    bus(1, `REG_OVR_MODE, 2);
    for (int i = 0; i < 24; i++)
    begin
      f = $random(seed);
      if (i < 2)
        f[11:0] = i ? 12'h7FF : 12'h800;
      bd = {$random(seed), $random(seed)};
      sd = {$random(seed), $random(seed)};
      issue({f[0] ? `OPC_ST : `OPC_LD, 10'h42, f[15:0]});
      chk("mem_req", 1, mem_req);
      chk("mem_write", f[0], mem_write);
      chk("mem_addr", ea(bd, f[15:0]), mem_addr);
      chk("mem_phys", f[15], mem_phys);
      chk("mem_lock", f[15] & f[14], mem_lock);
      chk("mem_quad", f[12], mem_quad);
      chk("mem_wdata", sd, mem_wdata);
      if (!f[15])
        chk("mem_mode", f[14] ? 2 : 1, mem_mode);
      chk("write_check", !f[0] & !f[15] & f[13], mem_write_check);
    end
    operand_hazard <= 1'b1;
    hold({`OPC_LD, 10'h42, 16'h0});
    operand_hazard <= 1'b0;
    for (int s = 1; s < 8; s++)
    begin
      sd = {$random(seed), $random(seed)};
      issue({`OPC_MTPR, 10'h63, 8'h0, 3'(s), 5'(s + 8)});
      chk("mem_ipr_we", s[1], mem_ipr_we);
      chk("fetch_ipr_we", s[0], fetch_ipr_we);
      chk("ipr_wdata", sd, ipr_wdata);
      chk("ipr_index", s + 8, ipr_index);
      for (int b = 0; b < 3; b++)
        if (s[b])
        begin
          issue({`OPC_MFPR, 10'h63, 8'h0, 3'(1 << b), 5'(s + 8)});
          chk("gpr_we", 1, gpr_we);
          chk("gpr_wdata", sd, gpr_wdata);
          chk("gpr_index", 3, gpr_index);
        end
    end
    x = {$random(seed), $random(seed)} | 64'h3;
    hold({`OPC_REI, 10'h0FF, 16'h8000});
    rei(x);
    rei(x & ~64'h1);
    foreach (ops[i])
    begin
      issue({ops[i], 10'h3FF, 16'h00E1});
      chk("fault", 1, illegal_opcode_fault);
      chk("effects", 0, {mem_req, gpr_we, mem_ipr_we, fetch_ipr_we, redirect});
    end
    bus(1, `REG_FETCH_CTRL, 1);
    ldf(1);
    bus(1, `REG_CUR_MODE, 0);
    ldf(0);
    bus(1, `REG_FETCH_CTRL, 0);
    ldf(1);
    exc_pc <= {$random(seed), $random(seed)};
    enter_firmware <= 1'b1;
    @(posedge sys_clk);
    enter_firmware <= 1'b0;
    bus(0, `REG_EXC_LO, 0);
    chk("exc_lo", exc_pc[31:0], rd);
    ldf(0);
    rstn <= 1'b0;
    @(posedge sys_clk);
    rstn <= 1'b1;
    chk("firmware_mode", 1, firmware_mode);
    chk("fetch_pointer", 0, fetch_pointer);
    bus(0, `REG_STATUS, 0);
    chk("status", 32'h1, rd);
    results();
  end
endmodule // testbench
